// ---- quad_dac_pkg.sv ----
// constants and types shared by both ends of the quad converter serial link
package quad_dac_pkg;
    localparam int FRAME_BITS      = 24;
    localparam int CH_NUM          = 4;
    localparam int DATA_BITS       = 16;
    localparam int PD_BITS         = 2;
    localparam int ENTRY_BITS      = PD_BITS + DATA_BITS;
    localparam int LOAD_ALL_POS    = 21;
    localparam int LOAD_SINGLE_POS = 20;
    localparam int UNUSED_CTRL_POS = 19;
    localparam int SEL_HI_POS      = 18;
    localparam int SEL_LO_POS      = 17;
    localparam int PD_FLAG_POS     = 16;
    localparam int PD_HI_POS       = 15;
    localparam int PD_LO_POS       = 14;
    localparam logic [4:0]  LAST_EDGE_CNT  = 5'h17;
    localparam logic [4:0]  DONE_CNT       = 5'h18;
    localparam logic [1:0]  PD_NONE        = 2'h0;
    localparam logic [1:0]  PD_1K          = 2'h1;
    localparam logic [1:0]  PD_100K        = 2'h2;
    localparam logic [1:0]  PD_HIZ         = 2'h3;
    localparam logic [15:0] ZERO_SCALE     = 16'h0000;
    localparam logic [15:0] MID_SCALE      = 16'h8000;
    localparam logic [1:0]  STRAP_SETTLE   = 2'h2;
    // host serial clock is system clock divided by two: 200 ns period
    localparam logic [4:0]  HOST_LAST_BIT  = 5'h17;
    typedef logic [ENTRY_BITS-1:0] entry_t;
    typedef enum logic [1:0]
    {
        H_IDLE  = 2'b00,
        H_LEAD  = 2'b01,
        H_SHIFT = 2'b10,
        H_TAIL  = 2'b11
    } host_state_t;
endpackage

// ---- dac_link_if.sv ----
// three-wire serial link plus load trigger and port disable pins
`timescale 1ns/1ps
interface dac_link_if;
    logic frame_n;
    logic sclk;
    logic sdata;
    logic async_load_trigger;
    logic port_disable;
    modport device
    (
        input frame_n,
        input sclk,
        input sdata,
        input async_load_trigger,
        input port_disable
    );
    modport host
    (
        output frame_n,
        output sclk,
        output sdata,
        output async_load_trigger,
        output port_disable
    );
endinterface

// ---- quad_dac_device.sv ----
// converter end: serial shifter on the link clock, channel registers on i_clk
`timescale 1ns/1ps
module quad_dac_device
    import quad_dac_pkg::*;
(
    dac_link_if.device                    link,
    input  wire logic                     i_clk,
    input  wire logic                     i_rst_n,
    input  wire logic                     i_reset_level_select,
    output logic [CH_NUM-1:0][DATA_BITS-1:0] o_channel_code,
    output logic [CH_NUM-1:0][PD_BITS-1:0]   o_channel_pd
);
    typedef struct packed
    {
        logic [4:0]            cnt;
        logic [FRAME_BITS-2:0] shift;
    } shift_t;

    typedef struct packed
    {
        logic [FRAME_BITS-1:0] word;
        logic                  toggle;
    } capture_t;

    typedef struct packed
    {
        logic                     tog_s1;
        logic                     tog_s2;
        logic                     tog_s3;
        logic                     ld_s1;
        logic                     ld_s2;
        logic                     ld_s3;
        logic                     rs_s1;
        logic                     rs_s2;
        logic [1:0]               init_cnt;
        logic                     init_done;
        logic [CH_NUM-1:0][ENTRY_BITS-1:0] temp_buffer_reg;
        logic [CH_NUM-1:0][ENTRY_BITS-1:0] output_hold_reg;
    } core_t;

    shift_t   sh_q;
    shift_t   sh_d;
    capture_t cap_q;
    capture_t cap_d;
    core_t    core_q;
    core_t    core_d;
    logic     link_clr_n;

    // builds a buffer entry from a frame; plain data clears power-down
    function automatic entry_t frame_entry(input logic [FRAME_BITS-1:0] w);
        entry_t e;
        e[DATA_BITS-1:0] = w[DATA_BITS-1:0];
        if (w[PD_FLAG_POS])
        begin
            e[ENTRY_BITS-1:DATA_BITS] = w[PD_HI_POS:PD_LO_POS];
        end
        else
        begin
            e[ENTRY_BITS-1:DATA_BITS] = PD_NONE;
        end
        return e;
    endfunction

    // frame end or port disable clears the shifter at once
    assign link_clr_n = i_rst_n & ~link.frame_n & ~link.port_disable;

    // link domain: sampled on falling serial clock edge
    always_comb
    begin
        sh_d  = sh_q;
        cap_d = cap_q;
        if (sh_q.cnt != DONE_CNT)
        begin
            sh_d.shift = {sh_q.shift[FRAME_BITS-3:0], link.sdata};
            sh_d.cnt   = sh_q.cnt + 5'h01;
            if (sh_q.cnt == LAST_EDGE_CNT)
            begin
                cap_d.word   = {sh_q.shift, link.sdata};
                cap_d.toggle = ~cap_q.toggle;
            end
        end
    end

    always_ff @(negedge link.sclk or negedge link_clr_n)
    begin
        if (!link_clr_n)
        begin
            sh_q <= '0;
        end
        else
        begin
            sh_q <= sh_d;
        end
    end

    // capture only moves on a complete frame, so a short one changes nothing
    always_ff @(negedge link.sclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cap_q <= '0;
        end
        else if (link_clr_n)
        begin
            cap_q <= cap_d;
        end
    end

    // core domain
    always_comb
    begin
        logic                          frame_evt;
        logic                          load_rise;
        logic [1:0]                    sel;
        logic [FRAME_BITS-1:0]         w;
        logic [DATA_BITS-1:0]          rst_code;
        core_d    = core_q;
        w         = cap_q.word;
        sel       = w[SEL_HI_POS:SEL_LO_POS];
        frame_evt = core_q.tog_s2 ^ core_q.tog_s3;
        load_rise = core_q.ld_s2 & ~core_q.ld_s3;
        rst_code  = core_q.rs_s2 ? MID_SCALE : ZERO_SCALE;

        core_d.tog_s1 = cap_q.toggle;
        core_d.tog_s2 = core_q.tog_s1;
        core_d.tog_s3 = core_q.tog_s2;
        core_d.ld_s1  = link.async_load_trigger;
        core_d.ld_s2  = core_q.ld_s1;
        core_d.ld_s3  = core_q.ld_s2;
        core_d.rs_s1  = i_reset_level_select;
        core_d.rs_s2  = core_q.rs_s1;

        if (!core_q.init_done)
        begin
            if (core_q.init_cnt == STRAP_SETTLE)
            begin
                core_d.init_done = 1'b1;
                for (int i = 0; i < CH_NUM; i++)
                begin
                    core_d.temp_buffer_reg[i] = {PD_NONE, rst_code};
                    core_d.output_hold_reg[i] = {PD_NONE, rst_code};
                end
            end
            else
            begin
                core_d.init_cnt = core_q.init_cnt + 2'h1;
            end
        end
        else
        begin
            if (frame_evt)
            begin
                core_d.temp_buffer_reg[sel] = frame_entry(w);
                if (w[LOAD_ALL_POS])
                begin
                    for (int i = 0; i < CH_NUM; i++)
                    begin
                        core_d.output_hold_reg[i] = core_d.temp_buffer_reg[i];
                    end
                end
                else if (w[LOAD_SINGLE_POS])
                begin
                    core_d.output_hold_reg[sel] = core_d.temp_buffer_reg[sel];
                end
            end
            if (load_rise)
            begin
                // copying an unchanged buffer leaves its output as it was
                for (int i = 0; i < CH_NUM; i++)
                begin
                    core_d.output_hold_reg[i] = core_d.temp_buffer_reg[i];
                end
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            core_q <= '0;
        end
        else
        begin
            core_q <= core_d;
        end
    end

    always_comb
    begin
        for (int i = 0; i < CH_NUM; i++)
        begin
            o_channel_code[i] = core_q.output_hold_reg[i][DATA_BITS-1:0];
            o_channel_pd[i]   = core_q.output_hold_reg[i][ENTRY_BITS-1:DATA_BITS];
        end
    end
endmodule

// ---- quad_dac_host.sv ----
// host end: sends 24-bit frames msb first with a divided serial clock
`timescale 1ns/1ps
module quad_dac_host
    import quad_dac_pkg::*;
(
    dac_link_if.host                   link,
    input  wire logic                  i_clk,
    input  wire logic                  i_rst_n,
    input  wire logic                  i_start,
    input  wire logic [FRAME_BITS-1:0] i_frame,
    input  wire logic                  i_async_load,
    input  wire logic                  i_port_disable,
    output logic                       o_busy,
    output logic                       o_done
);
    typedef struct packed
    {
        host_state_t           state;
        logic [FRAME_BITS-1:0] word;
        logic [4:0]            bit_idx;
        logic                  frame_n;
        logic                  sclk;
        logic                  sdata;
        logic                  load;
        logic                  pdis;
        logic                  busy;
        logic                  done;
    } host_reg_t;

    host_reg_t q;
    host_reg_t d;

    always_comb
    begin
        d      = q;
        d.done = 1'b0;
        d.load = i_async_load;
        d.pdis = i_port_disable;
        unique case (q.state)
            H_IDLE:
            begin
                if (i_start)
                begin
                    d.word    = i_frame;
                    d.bit_idx = HOST_LAST_BIT;
                    d.frame_n = 1'b0;
                    d.busy    = 1'b1;
                    d.state   = H_LEAD;
                end
            end
            H_LEAD:
            begin
                d.state = H_SHIFT;
            end
            H_SHIFT:
            begin
                if (!q.sclk)
                begin
                    d.sclk  = 1'b1;
                    d.sdata = q.word[q.bit_idx];
                end
                else
                begin
                    d.sclk = 1'b0;
                    if (q.bit_idx == 5'h00)
                    begin
                        d.state = H_TAIL;
                    end
                    else
                    begin
                        d.bit_idx = q.bit_idx - 5'h01;
                    end
                end
            end
            H_TAIL:
            begin
                // frame held low over all 24 bits before release
                d.frame_n = 1'b1;
                d.busy    = 1'b0;
                d.done    = 1'b1;
                d.state   = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            q         <= '0;
            q.frame_n <= 1'b1;
            q.pdis    <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign link.frame_n            = q.frame_n;
    assign link.sclk               = q.sclk;
    assign link.sdata              = q.sdata;
    assign link.async_load_trigger = q.load;
    assign link.port_disable       = q.pdis;
    assign o_busy                  = q.busy;
    assign o_done                  = q.done;
endmodule

// ---- dac_link_properties.sv ----
// timing checks on the host-driven serial link pins
`timescale 1ns/1ps
module dac_link_properties
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic frame_n,
    input wire logic sclk,
    input wire logic sdata
);
    logic [5:0] fall_cnt_q;
    logic       sclk_prev_q;
    // counts falling link clock edges inside the current frame
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            fall_cnt_q  <= 6'h00;
            sclk_prev_q <= 1'b0;
        end
        else
        begin
            sclk_prev_q <= sclk;
            if (frame_n)
            begin
                fall_cnt_q <= 6'h00;
            end
            else if (sclk_prev_q && !sclk)
            begin
                fall_cnt_q <= fall_cnt_q + 6'h01;
            end
        end
    end
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    sequence s_bit;
        sclk ##1 !sclk;
    endsequence
    // one idle clock sample after the frame falls, then the first bit cell
    sequence s_lead;
        !sclk ##1 !sclk ##1 s_bit;
    endsequence
    property p_sclk_idle; frame_n |-> !sclk; endproperty
    a_sclk_idle: assert property (p_sclk_idle) else $error("clock outside frame");
    property p_frame_start; $fell(frame_n) |-> s_lead; endproperty
    a_frame_start: assert property (p_frame_start) else $error("bad frame lead");
    property p_bit_cell; $rose(sclk) |=> !sclk; endproperty
    a_bit_cell: assert property (p_bit_cell) else $error("clock high too long");
    property p_sdata_on_rise;
        !frame_n && !$fell(frame_n) && $changed(sdata) |-> $rose(sclk);
    endproperty
    a_sdata_on_rise: assert property (p_sdata_on_rise) else $error("data off rise");
    property p_hold_fall; $fell(sclk) |-> $stable(sdata); endproperty
    a_hold_fall: assert property (p_hold_fall) else $error("data moved at fall");
    property p_edge_count; $rose(frame_n) |-> fall_cnt_q == 6'h18; endproperty
    a_edge_count: assert property (p_edge_count) else $error("frame edge count");
    property p_edge_limit; fall_cnt_q <= 6'h18; endproperty
    a_edge_limit: assert property (p_edge_limit) else $error("too many edges");
    property p_frame_span;
        $fell(frame_n) |-> (!frame_n throughout ##49 1'b1) ##1 frame_n;
    endproperty
    a_frame_span: assert property (p_frame_span) else $error("frame span");
endmodule

// ---- quad_dac_serial_update_control_bench.sv ----
// self-checking bench joining host and device ends of the link
`timescale 1ns/1ps
module quad_dac_serial_update_control_bench;
    import quad_dac_pkg::*;
    logic                             i_clk = 1'b1;
    logic                             i_rst_n = 1'b1;
    logic                             strap = 1'b1;
    logic                             i_start = 1'b0;
    logic [FRAME_BITS-1:0]            i_frame = '0;
    logic                             i_async_load = 1'b0;
    logic                             i_port_disable = 1'b0;
    logic                             o_busy;
    logic                             o_done;
    logic [CH_NUM-1:0][DATA_BITS-1:0] code;
    logic [CH_NUM-1:0][PD_BITS-1:0]   pd;
    logic [FRAME_BITS-1:0]            rx_q;
    logic [DATA_BITS-1:0]             exp_code [CH_NUM];
    logic [PD_BITS-1:0]               exp_pd [CH_NUM];
    int                               num_errors = 0;
    int                               total_checks = 0;
    dac_link_if link();
    always #50 i_clk = ~i_clk;
    quad_dac_host quad_dac_host_inst
    (
        .link(link), .i_clk(i_clk), .i_rst_n(i_rst_n), .i_start(i_start),
        .i_frame(i_frame), .i_async_load(i_async_load),
        .i_port_disable(i_port_disable), .o_busy(o_busy), .o_done(o_done)
    );
    quad_dac_device quad_dac_device_inst
    (
        .link(link), .i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_reset_level_select(strap), .o_channel_code(code), .o_channel_pd(pd)
    );
    dac_link_properties dac_link_properties_inst
    (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .frame_n(link.frame_n),
        .sclk(link.sclk), .sdata(link.sdata)
    );
    // bits seen on the wire at each falling link clock edge
    always @(negedge link.sclk)
        if (!link.frame_n && !link.port_disable)
            rx_q <= {rx_q[FRAME_BITS-2:0], link.sdata};
    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    function automatic logic [FRAME_BITS-1:0] mk(input logic [1:0] ld, input logic [1:0] ch,
                                                 input logic pdf, input logic [15:0] d);
        return {2'h0, ld, 1'b1, ch, pdf, d};
    endfunction
    task automatic check_all(input string what);
        for (int c = 0; c < CH_NUM; c++)
        begin
            check(24'(code[c]), 24'(exp_code[c]), what);
            check(24'(pd[c]), 24'(exp_pd[c]), what);
        end
    endtask
    task automatic send(input logic [FRAME_BITS-1:0] f);
        int n;
        @(negedge i_clk);
        i_frame = f;
        i_start = 1'b1;
        @(negedge i_clk);
        i_start = 1'b0;
        check(24'(o_busy), 24'h1, "busy");
        n = 0;
        while (o_done !== 1'b1 && n < 100)
        begin
            @(negedge i_clk);
            n++;
        end
        check(24'(o_done), 24'h1, "done");
        check(24'(o_busy), 24'h0, "idle after frame");
        repeat (12) @(negedge i_clk);
        if (!i_port_disable)
            check(rx_q, f, "wire bits");
    endtask
    initial
    begin
        #1000000;
        num_errors++;
        complete_run();
    end
    initial
    begin
        for (int s = 1; s >= 0; s--)
        begin
            // reset falls after the first clock so every async clear sees an edge
            @(negedge i_clk);
            strap = s[0];
            i_rst_n = 1'b0;
            repeat (3) @(negedge i_clk);
            i_rst_n = 1'b1;
            repeat (6) @(negedge i_clk);
            for (int c = 0; c < CH_NUM; c++)
            begin
                exp_code[c] = s[0] ? MID_SCALE : ZERO_SCALE;
                exp_pd[c] = PD_NONE;
            end
            check_all("reset level");
        end
        for (int c = 0; c < CH_NUM; c++)
            send(mk(2'h0, c[1:0], 1'b0, 16'(16'h1111 * (c + 1))));
        check_all("buffer only");
        send(mk(2'h2, 2'h3, 1'b0, 16'hD00D));
        for (int c = 0; c < CH_NUM; c++)
            exp_code[c] = (c == 3) ? 16'hD00D : 16'(16'h1111 * (c + 1));
        check_all("load all");
        for (int c = 0; c < CH_NUM; c++)
        begin
            send(mk(2'h1, c[1:0], 1'b0, 16'(16'hA000 + c)));
            exp_code[c] = 16'(16'hA000 + c);
            check_all("single load");
        end
        for (int m = 1; m < 4; m++)
        begin
            send(mk(2'h1, 2'h0, 1'b1, {m[1:0], 14'h0000}));
            check(24'(pd[0]), 24'(m[1:0]), "pd mode");
            check(24'(code[0]), 24'({m[1:0], 14'h0000}), "pd data");
        end
        send(mk(2'h1, 2'h0, 1'b0, 16'h1234));
        exp_code[0] = 16'h1234;
        check_all("power up");
        send(mk(2'h0, 2'h1, 1'b0, 16'hBEEF));
        check_all("before trigger");
        i_async_load = 1'b1;
        repeat (10) @(negedge i_clk);
        i_async_load = 1'b0;
        exp_code[1] = 16'hBEEF;
        check_all("async load");
        fork
            send(mk(2'h1, 2'h2, 1'b0, 16'h5555));
            begin
                repeat (20) @(negedge i_clk);
                i_port_disable = 1'b1;
            end
        join
        i_port_disable = 1'b0;
        repeat (4) @(negedge i_clk);
        check_all("port disabled");
        send(mk(2'h3, 2'h2, 1'b0, 16'h5555));
        exp_code[2] = 16'h5555;
        check_all("load both bits");
        complete_run();
    end
endmodule
